// [design/sesr_consts.svh]
`ifndef SESR_CONSTS_SVH
`define SESR_CONSTS_SVH

// Register indices; the byte address on the bus is four times the index.
`define SESR_IDX_TRAP_INFO 18'h0fec0
`define SESR_IDX_STATUS 18'h0fec4
`define SESR_IDX_RESTART 18'h0fec8
`define SESR_IDX_HALT 18'h0fec9

// Field positions of the local interrupt source status word.
`define SESR_BIT_SPARE 22
`define SESR_BIT_L3 20
`define SESR_BIT_LINK 19
`define SESR_BIT_DRAM 18
`define SESR_BIT_LVT_EXT 17
`define SESR_BIT_LVT_LCY 16
`define SESR_BIT_PEND_MSG 10
`define SESR_BIT_CORES_HALTED 9
`define SESR_BIT_MCE_REDIR 8
`define SESR_IO_TRAP_MSB 3
`define SESR_IO_TRAP_LSB 0

// Field positions of the other words.
`define SESR_BIT_TRAP_VALID 1
`define SESR_BIT_HALT 0

// Reset and entry values, and the restart request code.
`define SESR_STATUS_RST 32'h0000_0000
`define SESR_RESTART_RST 8'h00
`define SESR_RESTART_ENTRY 8'h00
`define SESR_RESTART_REEXEC 8'hff
`define SESR_HALT_RST 1'h0

`endif

// [design/sesr_pkg.sv]
package sesr_pkg;

  // Causes and context that the core hands over with a management entry.
  typedef struct packed {
    logic spare;
    logic l3_thr;
    logic link_thr;
    logic dram_thr;
    logic lvt_ext;
    logic lvt_lcy;
    logic pend_msg;
    logic pend_msg_en;
    logic cores_halted;
    logic halt_src_en;
    logic mce_redir;
    logic redir_en;
    logic [3:0] io_trap;
    logic at_halt;
    logic at_io;
    logic dbg_trap;
  } sesr_src_t;

  // Actions that the block orders from the core on the way out.
  typedef struct packed {
    logic resume_ip;
    logic reexec_io;
    logic halt_cycle;
    logic enter_halt;
    logic debug_trap;
  } sesr_resume_t;

  // Sequencer states.
  typedef enum logic [3:0] {
    ST_RUN = 4'b0001,
    ST_SMM = 4'b0010,
    ST_REEXEC = 4'b0100,
    ST_WAIT = 4'b1000
  } sesr_state_t;

endpackage

// [design/sesr_smm_entry_status.sv]
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ns
`include "sesr_consts.svh"

// Overview of operation
// - On entry, set each status bit whose mechanism caused the interrupt.
// - Bit 22 flags an interrupt from the on-line spare memory sources.
// - Threshold interrupts flag bit 20 for L3, 19 for link, 18 for DRAM.
// - Bit 17 flags extended vector entries, bit 16 the legacy entries.
// - Bit 10 flags pending-message interrupts while that mechanism is enabled.
// - Bit 9 flags all cores halted with that source enabled.
// - Bit 8 flags a redirected machine check while redirect is enabled.
// - Bits 3 to 0 flag the matching numbered IO trap register.
// - Clear the restart byte to zero on every management entry.
// - Restart byte all ones at resume re-executes the trapped IO instruction.
// - A nested entry is serviced before re-execution and reports trap-valid zero.
// - Coinciding IO trap and debug trap: serve management first, defer debug.
// - With restart all ones, raise the deferred debug trap after re-execution.
// - Entry sets the halt bit to one from halt, zero otherwise.
// - Unless restart is all ones or re-execution is pending, resume obeys the halt bit: zero resumes at pointer, one halts.
// - Returning to halt skips refetch, broadcasts the halt cycle, then halts.
// - The restart byte is read-write in bits 7 to 0.
// - Trap-valid flag is one only for entry at an IO instruction boundary.
module sesr_smm_entry_status (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave.
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [19:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Entry request from the core.
  input wire logic smm_entry_i,
  input wire sesr_pkg::sesr_src_t entry_src_i,
  output logic entry_ready_o,
  // Resume request and re-execution feedback from the core.
  input wire logic rsm_i,
  input wire logic reexec_done_i,
  // Status towards the core.
  output logic in_smm_o,
  output logic handler_go_o,
  output sesr_pkg::sesr_resume_t resume_o
);

  // Sequencer and save-area state.
  sesr_pkg::sesr_state_t state_q;
  sesr_pkg::sesr_state_t state_d;
  logic [31:0] status_q;
  logic [31:0] status_d;
  logic [7:0] restart_q;
  logic [7:0] restart_d;
  logic halt_q;
  logic halt_d;
  logic trap_valid_q;
  logic trap_valid_d;
  logic dbg_defer_q;
  logic dbg_defer_d;
  logic reexec_pend_q;
  logic reexec_pend_d;
  logic go_q;
  logic go_d;
  sesr_pkg::sesr_resume_t act_q;
  sesr_pkg::sesr_resume_t act_d;

  // Bus state.
  logic ack_q;
  logic ack_d;
  logic [31:0] dat_q;
  logic [31:0] dat_d;

  // Decode helpers.
  logic bus_req;
  logic bus_wr;
  logic [17:0] bus_idx;
  logic entry_take;
  logic [31:0] entry_status;

  // A request is served once; the ack cycle itself is not a new request.
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  assign bus_idx = wb_adr_i[19:2];

  // Entries are accepted in normal execution or before a pending re-execution starts.
  assign entry_ready_o = (state_q == sesr_pkg::ST_RUN) | (state_q == sesr_pkg::ST_REEXEC);
  assign entry_take = smm_entry_i & entry_ready_o;

  // Build the status word from the causes; every position not named stays zero.
  always_comb begin
    entry_status = `SESR_STATUS_RST;
    entry_status[`SESR_BIT_SPARE] = entry_src_i.spare;
    entry_status[`SESR_BIT_L3] = entry_src_i.l3_thr;
    entry_status[`SESR_BIT_LINK] = entry_src_i.link_thr;
    entry_status[`SESR_BIT_DRAM] = entry_src_i.dram_thr;
    entry_status[`SESR_BIT_LVT_EXT] = entry_src_i.lvt_ext;
    entry_status[`SESR_BIT_LVT_LCY] = entry_src_i.lvt_lcy;
    entry_status[`SESR_BIT_PEND_MSG] = entry_src_i.pend_msg & entry_src_i.pend_msg_en;
    entry_status[`SESR_BIT_CORES_HALTED] =
      entry_src_i.cores_halted & entry_src_i.halt_src_en;
    entry_status[`SESR_BIT_MCE_REDIR] = entry_src_i.mce_redir & entry_src_i.redir_en;
    entry_status[`SESR_IO_TRAP_MSB:`SESR_IO_TRAP_LSB] = entry_src_i.io_trap;
  end

  // Next state of the sequencer and the save area.
  always_comb begin
    state_d = state_q;
    status_d = status_q;
    restart_d = restart_q;
    halt_d = halt_q;
    trap_valid_d = trap_valid_q;
    dbg_defer_d = dbg_defer_q;
    reexec_pend_d = reexec_pend_q;
    go_d = 1'b0;
    act_d = '0;
    // The halt broadcast is followed by the halt entry one cycle later.
    act_d.enter_halt = act_q.halt_cycle;
    // Handler writes reach the two read-write bytes through lane 0.
    if (bus_wr && (bus_idx == `SESR_IDX_RESTART)) begin
      restart_d = wb_dat_i[7:0];
    end
    if (bus_wr && (bus_idx == `SESR_IDX_HALT)) begin
      halt_d = wb_dat_i[`SESR_BIT_HALT];
    end
    case (state_q)
      sesr_pkg::ST_RUN, sesr_pkg::ST_REEXEC: begin
        if (entry_take) begin
          // Capture is complete at the next edge; the handler is released at that same edge.
          status_d = entry_status;
          go_d = 1'b1;
          restart_d = `SESR_RESTART_ENTRY;
          halt_d = entry_src_i.at_halt;
          // A nested entry never reports a valid trap.
          trap_valid_d = entry_src_i.at_io & (state_q == sesr_pkg::ST_RUN);
          // A coinciding debug trap waits until management mode is left.
          dbg_defer_d = dbg_defer_q | entry_src_i.dbg_trap;
          state_d = sesr_pkg::ST_SMM;
        end else if (state_q == sesr_pkg::ST_REEXEC) begin
          // No nested entry is waiting, so the trapped instruction runs now.
          act_d.reexec_io = 1'b1;
          reexec_pend_d = 1'b0;
          state_d = sesr_pkg::ST_WAIT;
        end
      end
      sesr_pkg::ST_SMM: begin
        if (rsm_i) begin
          if ((restart_q == `SESR_RESTART_REEXEC) || reexec_pend_q) begin
            // Re-execution is kept pending across a nested entry.
            reexec_pend_d = 1'b1;
            state_d = sesr_pkg::ST_REEXEC;
          end else if (halt_q) begin
            // Back to halt without refetch: broadcast the halt cycle first.
            act_d.halt_cycle = 1'b1;
            act_d.debug_trap = dbg_defer_q;
            dbg_defer_d = 1'b0;
            state_d = sesr_pkg::ST_RUN;
          end else begin
            act_d.resume_ip = 1'b1;
            act_d.debug_trap = dbg_defer_q;
            dbg_defer_d = 1'b0;
            state_d = sesr_pkg::ST_RUN;
          end
        end
      end
      sesr_pkg::ST_WAIT: begin
        if (reexec_done_i) begin
          // The deferred debug trap follows the re-executed instruction.
          act_d.debug_trap = dbg_defer_q;
          dbg_defer_d = 1'b0;
          state_d = sesr_pkg::ST_RUN;
        end
      end
      default: begin
        state_d = sesr_pkg::ST_RUN;
      end
    endcase
  end

  // Register the sequencer and the save area.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= sesr_pkg::ST_RUN;
      status_q <= `SESR_STATUS_RST;
      restart_q <= `SESR_RESTART_RST;
      halt_q <= `SESR_HALT_RST;
      trap_valid_q <= 1'b0;
      dbg_defer_q <= 1'b0;
      reexec_pend_q <= 1'b0;
      go_q <= 1'b0;
      act_q <= '0;
    end else begin
      state_q <= state_d;
      status_q <= status_d;
      restart_q <= restart_d;
      halt_q <= halt_d;
      trap_valid_q <= trap_valid_d;
      dbg_defer_q <= dbg_defer_d;
      reexec_pend_q <= reexec_pend_d;
      go_q <= go_d;
      act_q <= act_d;
    end
  end

  // Bus answer: one wait state, unmapped words read zero and ignore writes.
  always_comb begin
    ack_d = bus_req;
    dat_d = 32'h0000_0000;
    if (bus_req && !wb_we_i) begin
      case (bus_idx)
        `SESR_IDX_TRAP_INFO: begin
          dat_d[`SESR_BIT_TRAP_VALID] = trap_valid_q;
        end
        `SESR_IDX_STATUS: begin
          dat_d = status_q;
        end
        `SESR_IDX_RESTART: begin
          dat_d[7:0] = restart_q;
        end
        `SESR_IDX_HALT: begin
          dat_d[`SESR_BIT_HALT] = halt_q;
        end
        default: begin
          dat_d = 32'h0000_0000;
        end
      endcase
    end
  end

  // Register the bus answer.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      dat_q <= 32'h0000_0000;
    end else begin
      ack_q <= ack_d;
      dat_q <= dat_d;
    end
  end

  // Outputs.
  assign wb_ack_o = ack_q;
  assign wb_dat_o = dat_q;
  assign in_smm_o = (state_q == sesr_pkg::ST_SMM);
  assign handler_go_o = go_q;
  assign resume_o = act_q;

endmodule

// [testbench/sesr_smm_props.sv]
`timescale 1ns/1ns
`include "sesr_consts.svh"

// Checks entry, resume and status read timing at the ports.
module sesr_smm_props (
  // Watched ports.
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_we_i,
  input wire logic [19:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic smm_entry_i,
  input wire logic entry_ready_o,
  input wire logic rsm_i,
  input wire logic in_smm_o,
  input wire logic handler_go_o,
  input wire sesr_pkg::sesr_resume_t resume_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Each assertion ties an output to its cause.
  entry_go_a: assert property (smm_entry_i && entry_ready_o |=> handler_go_o && in_smm_o)
    else $error("entry not answered");
  go_once_a: assert property (handler_go_o |=> !handler_go_o)
    else $error("go longer than one cycle");
  smm_block_a: assert property (in_smm_o |-> !entry_ready_o)
    else $error("entry open in handler");
  rsm_exit_a: assert property (in_smm_o && rsm_i |=> !in_smm_o)
    else $error("resume not taken");
  halt_seq_a: assert property (resume_o.halt_cycle |=> resume_o.enter_halt)
    else $error("halt cycle not followed by halt");
  halt_only_a: assert property (resume_o.halt_cycle |-> !resume_o.resume_ip)
    else $error("halt and pointer resume together");
  dbg_late_a: assert property (resume_o.reexec_io |-> !resume_o.debug_trap)
    else $error("debug trap before re-execution");
  rsv_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i[19:2] == `SESR_IDX_STATUS
    |-> wb_dat_o[31:23] == 9'h0 && !wb_dat_o[21] && wb_dat_o[7:4] == 4'h0)
    else $error("reserved status bits set");
endmodule

bind sesr_smm_entry_status sesr_smm_props u_props (.clk_i, .rst_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .smm_entry_i, .entry_ready_o, .rsm_i, .in_smm_o, .handler_go_o,
  .resume_o);

// [testbench/tb.sv]
`timescale 1ns/1ns

// Drives the block, notes expected values in queues and compares them.
module tb;
  localparam logic [19:0] TI = 20'h3fb00, ST = 20'h3fb10, RS = 20'h3fb20, HL = 20'h3fb24;
  logic clk_i = 1'b0, rst_i = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic smm_entry_i = 1'b0, rsm_i = 1'b0, reexec_done_i = 1'b0;
  logic [19:0] wb_adr_i = '0;
  logic [3:0] wb_sel_i = '0;
  logic [31:0] wb_dat_i = '0, wb_dat_o;
  logic wb_ack_o, entry_ready_o, in_smm_o, handler_go_o;
  sesr_pkg::sesr_src_t entry_src_i = '0, s;
  sesr_pkg::sesr_resume_t resume_o;
  logic [31:0] dq[$];
  logic [4:0] rq[$];
  int fail_count = 0, checked = 0, n;

  sesr_smm_entry_status DUT (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
    .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .smm_entry_i, .entry_src_i, .entry_ready_o,
    .rsm_i, .reexec_done_i, .in_smm_o, .handler_go_o, .resume_o);

  // Clock of 8 ns.
  initial begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // One classic cycle, held until ack.
  task automatic bus(input logic w, input logic [19:0] a, input logic [31:0] d,
                     input logic [3:0] m);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, m};
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) fail_count++;
    if (n >= 20) stop_test();
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask

  task automatic rd(input logic [19:0] a, input logic [31:0] e);
    dq.push_back(e);
    bus(1'b0, a, 32'h0, 4'hf);
  endtask

  // Entry request; with nest set it is made in the cycle after a resume.
  task automatic enter(input logic nest);
    @(posedge clk_i);
    if (nest) rsm_i <= 1'b1;
    if (nest) @(posedge clk_i);
    rsm_i <= 1'b0;
    smm_entry_i <= 1'b1;
    entry_src_i <= s;
    @(posedge clk_i);
    smm_entry_i <= 1'b0;
  endtask

  task automatic resume;
    @(posedge clk_i);
    rsm_i <= 1'b1;
    @(posedge clk_i);
    rsm_i <= 1'b0;
  endtask

  function automatic logic [31:0] stat(sesr_pkg::sesr_src_t v);
    return {9'h0, v.spare, 1'b0, v.l3_thr, v.link_thr, v.dram_thr, v.lvt_ext, v.lvt_lcy,
      5'h0, v.pend_msg & v.pend_msg_en, v.cores_halted & v.halt_src_en,
      v.mce_redir & v.redir_en, 4'h0, v.io_trap};
  endfunction

  // Compares each read and each resume pulse with the oldest note.
  always @(posedge clk_i) begin
    if (!rst_i && wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      chk("read data", wb_dat_o, dq.pop_front());
    if (!rst_i && resume_o !== 5'h0)
      chk("resume", 32'(resume_o), 32'(rq.pop_front()));
  end

  // Main sequence.
  initial begin
    void'($urandom(32'h9439));
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ST, 0);
    rd(RS, 0);
    rd(HL, 0);
    rd(20'h00040, 0);
    $display("test reset done");
    for (int i = 0; i < 8; i++) begin
      s = 19'($urandom);
      bus(1'b1, RS, 32'h5a, 4'h1);
      enter(1'b0);
      bus(1'b1, ST, 32'hffff_ffff, 4'hf);
      bus(1'b1, RS, 32'hff, 4'h0);
      rd(ST, stat(s));
      rd(RS, 0);
      rd(HL, 32'(s.at_halt));
      rd(TI, {30'h0, s.at_io, 1'b0});
      bus(1'b1, HL, 32'(i % 2), 4'h1);
      rq.push_back((i % 2 ? 5'h04 : 5'h10) | 5'(s.dbg_trap));
      if (i % 2) rq.push_back(5'h02);
      resume();
      repeat (3) @(posedge clk_i);
    end
    $display("test entry done");
    // Trapped IO, debug trap deferred, nested entry before re-execution.
    s = 19'($urandom);
    {s.at_io, s.at_halt, s.dbg_trap} = 3'b101;
    enter(1'b0);
    bus(1'b1, RS, 32'hff, 4'h1);
    rd(RS, 32'hff);
    s.dbg_trap = 1'b0;
    enter(1'b1);
    rd(TI, 0);
    rq.push_back(5'h08);
    rq.push_back(5'h01);
    resume();
    n = 0;
    while (resume_o.reexec_io !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    reexec_done_i <= 1'b1;
    @(posedge clk_i);
    reexec_done_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    chk("pending notes", rq.size() + dq.size() + (n >= 20), 0);
    $display("test reexec done");
    stop_test();
  end
endmodule
